// file: sfp_pkg.sv
// Package for the serial flash protocol front end: types and constants
package sfp_pkg;

	// ------------------------------------------------------------
	// Protocol selection
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SFP_PROTO_EXT,
		SFP_PROTO_DUAL,
		SFP_PROTO_QUAD
	} sfp_proto_t;

	// Lane width codes used for receive and transmit shifting
	typedef enum logic [1:0] {
		SFP_LANE_X1,
		SFP_LANE_X2,
		SFP_LANE_X4
	} sfp_lane_t;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int          SFP_EVCR_QUAD_N_BIT = 7;
	localparam int          SFP_EVCR_DUAL_N_BIT = 6;
	localparam int          SFP_NVCR_DUAL_N_BIT = 2;
	localparam int          SFP_NVCR_QUAD_N_BIT = 3;
	localparam int          SFP_LANES           = 4;
	localparam int          SFP_BYTE_BITS       = 8;
	localparam int          SFP_FIFO_DEPTH      = 16;
	localparam logic [3:0]  SFP_CNT_BYTE        = 4'h8;
	localparam logic [3:0]  SFP_CNT_ZERO        = 4'h0;
	localparam logic [2:0]  SFP_PULSE_ZERO      = 3'h0;
	localparam logic [7:0]  SFP_BYTE_ZERO       = 8'h00;
	localparam logic [3:0]  SFP_LANE_IDLE       = 4'h0;
	localparam logic [1:0]  SFP_SYNC_IDLE_LOW   = 2'h0;
	localparam logic [1:0]  SFP_SYNC_IDLE_HIGH  = 2'h3;
	localparam sfp_proto_t  SFP_PROTO_RESET     = SFP_PROTO_EXT;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	// One received byte and whether it was the command byte
	typedef struct packed {
		logic       cmd;
		logic [7:0] data;
	} sfp_rx_t;

	localparam int SFP_RX_W = $bits(sfp_rx_t);

	// End of frame report towards the command logic
	typedef struct packed {
		logic end_pulse;
		logic whole_bytes;
	} sfp_frame_t;

endpackage : sfp_pkg

// file: sfp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module sfp_fifo
	import sfp_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;

	assign in_ready  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_ff[rd_ptr_ff];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end

endmodule : sfp_fifo

// file: sfp_frontend.sv
// Serial flash protocol front end: pin sampling, lane shifting and protocol selection
module sfp_frontend
	import sfp_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// Pins from the bus master
	input  wire logic             sclk_pin,
	input  wire logic             chip_sel_n_pin,
	input  wire logic [3:0]       serial_data_lines_in,
	output logic      [3:0]       serial_data_lines_out,
	output logic      [3:0]       serial_data_lines_oe,
	input  wire logic             hv_supply_pin,
	// Nonvolatile straps read at power-on
	input  wire logic             nv_dual_n,
	input  wire logic             nv_quad_n,
	// Command logic side
	input  wire sfp_lane_t        phase_width,
	input  wire logic             out_phase,
	input  wire logic             busy_pe,
	input  wire logic             evcr_wr_req,
	input  wire logic [7:0]       evcr_value,
	input  wire logic             rescue,
	input  wire logic [7:0]       tx_data,
	input  wire logic             tx_valid,
	output logic                  tx_ready,
	output sfp_rx_t               rx_data,
	output logic                  rx_valid,
	input  wire logic             rx_ready,
	output sfp_frame_t            frame,
	output logic                  rx_overrun,
	output sfp_proto_t            proto,
	output logic                  ext_fallback,
	output logic                  selected
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] sclk_sync_ff;
	logic [1:0] cs_n_sync_ff;
	logic [1:0] hv_sync_ff;
	logic [3:0] din_meta_ff;
	logic [3:0] din_sync_ff;
	logic       sclk_prev_ff;
	logic       cs_n_prev_ff;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sclk_sync_ff <= SFP_SYNC_IDLE_LOW;
			cs_n_sync_ff <= SFP_SYNC_IDLE_HIGH;
			hv_sync_ff   <= SFP_SYNC_IDLE_LOW;
			din_meta_ff  <= SFP_LANE_IDLE;
			din_sync_ff  <= SFP_LANE_IDLE;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[0], sclk_pin};
			cs_n_sync_ff <= {cs_n_sync_ff[0], chip_sel_n_pin};
			hv_sync_ff   <= {hv_sync_ff[0], hv_supply_pin};
			din_meta_ff  <= serial_data_lines_in;
			din_sync_ff  <= din_meta_ff;
		end
	end

	// Edge detectors look at the second stage only
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sclk_prev_ff <= 1'b0;
			cs_n_prev_ff <= 1'b1;
		end else begin
			sclk_prev_ff <= sclk_sync_ff[1];
			cs_n_prev_ff <= cs_n_sync_ff[1];
		end
	end

	logic sel;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_end;
	logic hv_on;

	// Idle level of the clock is irrelevant: only edges inside a selection count
	assign sel       = !cs_n_sync_ff[1];
	assign sclk_rise = sel && sclk_sync_ff[1] && !sclk_prev_ff;
	assign sclk_fall = sel && !sclk_sync_ff[1] && sclk_prev_ff;
	assign frame_end = cs_n_sync_ff[1] && !cs_n_prev_ff;
	assign hv_on     = hv_sync_ff[1];
	assign selected  = sel;

	// ------------------------------------------------------------
	// Protocol selection
	// ------------------------------------------------------------
	sfp_proto_t proto_ff;
	sfp_proto_t nxt_proto;
	logic       boot_ff;
	logic       pend_ff;
	sfp_proto_t pend_proto_ff;
	logic       frame_ok;

	// Straps are read one cycle after reset release, never under reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			boot_ff <= 1'b1;
		end else begin
			boot_ff <= 1'b0;
		end
	end

	function automatic sfp_proto_t evcr_decode(input logic [7:0] v);
		sfp_proto_t p;
		p = SFP_PROTO_EXT;
		if (!v[SFP_EVCR_QUAD_N_BIT]) begin
			p = SFP_PROTO_QUAD;
		end else if (!v[SFP_EVCR_DUAL_N_BIT]) begin
			p = SFP_PROTO_DUAL;
		end
		return p;
	endfunction : evcr_decode

	// Latch the requested value during the frame, apply it when the frame closes after a multiple of eight clock pulses
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pend_ff       <= 1'b0;
			pend_proto_ff <= SFP_PROTO_RESET;
		end else if (frame_end) begin
			pend_ff <= 1'b0;
		end else if (sel && evcr_wr_req) begin
			pend_ff       <= 1'b1;
			pend_proto_ff <= evcr_decode(evcr_value);
		end
	end

	always_comb begin
		nxt_proto = proto_ff;
		if (boot_ff) begin
			if (!nv_quad_n) begin
				nxt_proto = SFP_PROTO_QUAD;
			end else if (!nv_dual_n) begin
				nxt_proto = SFP_PROTO_DUAL;
			end else begin
				nxt_proto = SFP_PROTO_EXT;
			end
		end else if (rescue) begin
			nxt_proto = SFP_PROTO_EXT;
		end else if (frame_end && pend_ff && frame_ok) begin
			nxt_proto = pend_proto_ff;
		end
	end

	// Power-on returns to the default before the straps are applied
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			proto_ff <= SFP_PROTO_RESET;
		end else begin
			proto_ff <= nxt_proto;
		end
	end

	assign proto = proto_ff;

	// ------------------------------------------------------------
	// Extended fall-back from quad during high-voltage program or erase
	// ------------------------------------------------------------
	logic fallback_ff;

	// Only changed between frames so a command is never split across widths
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fallback_ff <= 1'b0;
		end else if (!sel) begin
			if (proto_ff == SFP_PROTO_QUAD && hv_on && busy_pe) begin
				fallback_ff <= 1'b1;
			end else if (!hv_on) begin
				fallback_ff <= 1'b0;
			end
		end
	end

	assign ext_fallback = fallback_ff;

	// ------------------------------------------------------------
	// Lane width of the current phase
	// ------------------------------------------------------------
	logic      cmd_phase_ff;
	sfp_lane_t lane;

	always_comb begin
		lane = SFP_LANE_X1;
		if (fallback_ff || proto_ff == SFP_PROTO_EXT) begin
			lane = cmd_phase_ff ? SFP_LANE_X1 : phase_width;
		end else if (proto_ff == SFP_PROTO_DUAL) begin
			lane = SFP_LANE_X2;
		end else begin
			lane = SFP_LANE_X4;
		end
	end

	// ------------------------------------------------------------
	// Receive shifter
	// ------------------------------------------------------------
	logic [7:0] rx_shift_ff;
	logic [3:0] rx_cnt_ff;
	logic [2:0] pulse_cnt_ff;
	logic [7:0] nxt_rx_shift;
	logic [3:0] nxt_rx_cnt;
	logic       byte_done;

	always_comb begin
		nxt_rx_shift = rx_shift_ff;
		nxt_rx_cnt   = rx_cnt_ff;
		case (lane)
			SFP_LANE_X1: begin
				nxt_rx_shift = {rx_shift_ff[6:0], din_sync_ff[0]};
				nxt_rx_cnt   = rx_cnt_ff + 4'h1;
			end
			SFP_LANE_X2: begin
				nxt_rx_shift = {rx_shift_ff[5:0], din_sync_ff[1:0]};
				nxt_rx_cnt   = rx_cnt_ff + 4'h2;
			end
			SFP_LANE_X4: begin
				nxt_rx_shift = {rx_shift_ff[3:0], din_sync_ff};
				nxt_rx_cnt   = rx_cnt_ff + 4'h4;
			end
			default: begin
				nxt_rx_shift = rx_shift_ff;
				nxt_rx_cnt   = rx_cnt_ff;
			end
		endcase
	end

	assign byte_done = sclk_rise && !out_phase && (nxt_rx_cnt == SFP_CNT_BYTE);

	always_ff @(posedge clk_sys) begin
		if (rst || !sel) begin
			rx_shift_ff  <= SFP_BYTE_ZERO;
			rx_cnt_ff    <= SFP_CNT_ZERO;
			cmd_phase_ff <= 1'b1;
		end else if (sclk_rise && !out_phase) begin
			rx_shift_ff <= nxt_rx_shift;
			rx_cnt_ff   <= byte_done ? SFP_CNT_ZERO : nxt_rx_cnt;
			if (byte_done) begin
				cmd_phase_ff <= 1'b0;
			end
		end
	end

	// Clock pulses of the frame, modulo eight (one byte only at single width)
	always_ff @(posedge clk_sys) begin
		if (rst || frame_end) begin
			pulse_cnt_ff <= SFP_PULSE_ZERO;
		end else if (sclk_rise) begin
			pulse_cnt_ff <= pulse_cnt_ff + 3'h1;
		end
	end

	assign frame_ok = (pulse_cnt_ff == SFP_PULSE_ZERO);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			frame <= '0;
		end else begin
			frame.end_pulse   <= frame_end;
			frame.whole_bytes <= frame_end && frame_ok;
		end
	end

	// ------------------------------------------------------------
	// Received bytes buffer
	// ------------------------------------------------------------
	sfp_rx_t push_data;
	logic    push_ready;

	assign push_data.cmd  = cmd_phase_ff;
	assign push_data.data = nxt_rx_shift;

	// The pins cannot be stalled, so a full buffer drops the byte and flags it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rx_overrun <= 1'b0;
		end else if (byte_done && !push_ready) begin
			rx_overrun <= 1'b1;
		end else if (frame_end) begin
			rx_overrun <= 1'b0;
		end
	end

	sfp_fifo #(
		.WIDTH (SFP_RX_W),
		.DEPTH (SFP_FIFO_DEPTH)
	) u_rx_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_data   (push_data),
		.in_valid  (byte_done),
		.in_ready  (push_ready),
		.out_data  (rx_data),
		.out_valid (rx_valid),
		.out_ready (rx_ready)
	);

	// ------------------------------------------------------------
	// Transmit shifter
	// ------------------------------------------------------------
	logic [7:0] tx_shift_ff;
	logic [3:0] tx_cnt_ff;
	logic [3:0] dout_ff;
	logic       tx_load;
	logic [3:0] step;

	always_comb begin
		case (lane)
			SFP_LANE_X1: step = 4'h1;
			SFP_LANE_X2: step = 4'h2;
			SFP_LANE_X4: step = 4'h4;
			default:     step = 4'h1;
		endcase
	end

	assign tx_load  = sclk_fall && out_phase && (tx_cnt_ff == SFP_CNT_ZERO);
	assign tx_ready = tx_load;

	// Empty source sends ones; line data holds across deselect since the enable masks it
	always_ff @(posedge clk_sys) begin
		if (rst || !sel) begin
			tx_shift_ff <= SFP_BYTE_ZERO;
			tx_cnt_ff   <= SFP_CNT_ZERO;
			dout_ff     <= rst ? SFP_LANE_IDLE : dout_ff;
		end else if (sclk_fall && out_phase) begin
			if (tx_load) begin
				tx_shift_ff <= tx_valid ? tx_data : 8'hFF;
				tx_cnt_ff   <= SFP_CNT_BYTE - step;
				case (lane)
					SFP_LANE_X1: dout_ff <= {2'b00, (tx_valid ? tx_data[7] : 1'b1), 1'b0};
					SFP_LANE_X2: dout_ff <= {2'b00, (tx_valid ? tx_data[7:6] : 2'b11)};
					default:     dout_ff <= tx_valid ? tx_data[7:4] : 4'hF;
				endcase
			end else begin
				tx_cnt_ff <= tx_cnt_ff - step;
				case (lane)
					SFP_LANE_X1: begin
						tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
						dout_ff     <= {2'b00, tx_shift_ff[6], 1'b0};
					end
					SFP_LANE_X2: begin
						tx_shift_ff <= {tx_shift_ff[5:0], 2'b00};
						dout_ff     <= {2'b00, tx_shift_ff[5:4]};
					end
					default: begin
						tx_shift_ff <= {tx_shift_ff[3:0], 4'h0};
						dout_ff     <= tx_shift_ff[3:0];
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Output enables
	// ------------------------------------------------------------
	logic [3:0] oe_ff;

	always_ff @(posedge clk_sys) begin
		if (rst || !sel) begin
			oe_ff <= SFP_LANE_IDLE;
		end else if (tx_load) begin
			case (lane)
				SFP_LANE_X1: oe_ff <= 4'b0010;
				SFP_LANE_X2: oe_ff <= 4'b0011;
				default:     oe_ff <= 4'b1111;
			endcase
		end else if (!out_phase) begin
			oe_ff <= SFP_LANE_IDLE;
		end
	end

	// Gated with select so release does not wait for the registered path
	assign serial_data_lines_oe  = sel ? oe_ff : SFP_LANE_IDLE;
	assign serial_data_lines_out = dout_ff;

endmodule : sfp_frontend

// file: sfp_monitor.sv
// Port checker for the serial flash protocol front end
module sfp_monitor
	import sfp_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       sclk_pin,
	input wire logic       chip_sel_n_pin,
	input wire logic       hv_supply_pin,
	input wire logic       busy_pe,
	input wire logic       rescue,
	input wire logic [3:0] serial_data_lines_out,
	input wire logic [3:0] serial_data_lines_oe,
	input wire logic       tx_ready,
	input wire sfp_frame_t frame,
	input wire sfp_proto_t proto,
	input wire logic       ext_fallback,
	input wire logic       selected
);
	timeunit 1ns;
	timeprecision 100ps;

	logic       sclk_q_ff;
	logic [3:0] fall_age_ff;
	logic [2:0] rst_age_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// --------------------
	// Helper counters
	// --------------------
	// Age of the last pin fall, saturating so idle gaps never wrap
	always_ff @(posedge clk_sys) begin
		sclk_q_ff <= sclk_pin;
		if (rst) begin
			fall_age_ff <= 4'hF;
		end else if (sclk_q_ff && !sclk_pin) begin
			fall_age_ff <= 4'h0;
		end else if (fall_age_ff != 4'hF) begin
			fall_age_ff <= fall_age_ff + 4'h1;
		end
	end

	// Masks strap loading just after reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rst_age_ff <= 3'h0;
		end else if (rst_age_ff != 3'h7) begin
			rst_age_ff <= rst_age_ff + 3'h1;
		end
	end

	// --------------------
	// Properties
	// --------------------
	sequence quad_busy;
		proto == SFP_PROTO_QUAD && hv_supply_pin && busy_pe && chip_sel_n_pin;
	endsequence
	sequence hv_idle;
		!hv_supply_pin && chip_sel_n_pin;
	endsequence

	oe_release_a: assert property (!selected |-> serial_data_lines_oe == 4'h0)
		else $error("lines driven while deselected");
	reset_state_a: assert property (disable iff (1'b0) rst |=> proto == SFP_PROTO_EXT && !ext_fallback)
		else $error("reset state wrong");
	frame_pulse_a: assert property (frame.end_pulse |=> !frame.end_pulse)
		else $error("frame end longer than one cycle");
	whole_count_a: assert property (frame.whole_bytes |-> frame.end_pulse)
		else $error("whole bytes flag outside frame end");
	proto_switch_a: assert property ($changed(proto) && proto != SFP_PROTO_EXT && rst_age_ff == 3'h7
		|-> $past(frame.end_pulse && frame.whole_bytes) || (frame.end_pulse && frame.whole_bytes))
		else $error("protocol changed without whole frame");
	rescue_ext_a: assert property (rescue |-> ##[1:3] proto == SFP_PROTO_EXT)
		else $error("rescue did not restore default");
	fb_on_a: assert property (quad_busy [*5] |=> ext_fallback)
		else $error("fall-back not entered");
	fb_off_a: assert property (hv_idle [*5] |=> !ext_fallback)
		else $error("fall-back not left");
	fb_quad_a: assert property (ext_fallback |-> proto == SFP_PROTO_QUAD)
		else $error("fall-back outside quad");
	out_edge_a: assert property ($changed(serial_data_lines_out) && rst_age_ff == 3'h7
		|-> fall_age_ff inside {[4'h1:4'h7]})
		else $error("output changed away from falling edge");
	tx_take_a: assert property (tx_ready |-> selected ##1 !tx_ready)
		else $error("transmit take outside frame");
endmodule : sfp_monitor

bind sfp_frontend sfp_monitor u_mon (
	.clk_sys(clk_sys), .rst(rst), .sclk_pin(sclk_pin), .chip_sel_n_pin(chip_sel_n_pin),
	.hv_supply_pin(hv_supply_pin), .busy_pe(busy_pe), .rescue(rescue),
	.serial_data_lines_out(serial_data_lines_out), .serial_data_lines_oe(serial_data_lines_oe),
	.tx_ready(tx_ready), .frame(frame), .proto(proto), .ext_fallback(ext_fallback), .selected(selected)
);

// file: sfp_master.sv
// Bus master model that drives the serial pins
module sfp_master
	import sfp_pkg::*;
(
	input  wire logic       clk_sys,
	output logic            sclk,
	output logic            cs_n,
	output logic [3:0]      m_out,
	output logic [3:0]      m_oe,
	input  wire logic [3:0] dq
);
	timeunit 1ns;
	timeprecision 100ps;

	logic idle_hi;

	// Spare lines held high so protect and hold only float while the master releases all lines for a read
	initial begin
		idle_hi = 1'b0;
		sclk    = 1'b0;
		cs_n    = 1'b1;
		m_out   = 4'hF;
		m_oe    = 4'hF;
	end

	task automatic half();
		repeat (4) @(posedge clk_sys);
		#1;
	endtask : half

	// Clock parks at the mode's idle level between frames
	task automatic start(input logic mode3);
		idle_hi = mode3;
		sclk    = mode3;
		m_oe    = 4'hF;
		half();
		cs_n = 1'b0;
		half();
	endtask : start

	// MSB first; reads sampled late in the high phase, after the device settles
	task automatic xbits(input logic [7:0] b, input int w, input int n, input logic drv, output logic [7:0] r);
		logic [7:0] sh;
		sh   = b;
		r    = 8'h00;
		m_oe = drv ? 4'hF : 4'h0;
		for (int k = 0; k < n; k++) begin
			sclk  = 1'b0;
			m_out = (w == 4) ? sh[7:4] : (w == 2) ? {2'b11, sh[7:6]} : {3'b111, sh[7]};
			sh    = sh << w;
			half();
			sclk = 1'b1;
			half();
			r = (w == 4) ? {r[3:0], dq} : (w == 2) ? {r[5:0], dq[1:0]} : {r[6:0], dq[1]};
		end
	endtask : xbits

	task automatic stop();
		if (!idle_hi) begin
			sclk = 1'b0;
			half();
		end
		cs_n = 1'b1;
		half();
		half();
	endtask : stop
endmodule : sfp_master

// file: sfp_testbench.sv
// Self-checking bench for the serial flash protocol front end
module testbench
	import sfp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic       clk_sys, rst, sclk, cs_n, hv, nv_d, nv_q, out_phase, busy_pe, evcr_wr_req;
	logic       rescue, tx_valid, rx_ready, flt, tx_ready, rx_valid, rx_overrun, ext_fallback, selected;
	logic [7:0] evcr_value, tx_data;
	logic [3:0] m_out, m_oe, dq_o, dq_e, dq;
	sfp_lane_t  pw;
	sfp_rx_t    rx_data;
	sfp_frame_t frame;
	sfp_proto_t proto, exp_p;
	logic       exp_fb, exp_whole;
	int         n_errors, checked, seed;
	int         exp_q[$];

	// Released lines toggle so a stale level never passes
	assign dq = (dq_e & dq_o) | (~dq_e & m_oe & m_out) | (~dq_e & ~m_oe & {4{flt}});

	sfp_frontend dut (
		.clk_sys(clk_sys), .rst(rst), .sclk_pin(sclk), .chip_sel_n_pin(cs_n),
		.serial_data_lines_in(dq), .serial_data_lines_out(dq_o), .serial_data_lines_oe(dq_e),
		.hv_supply_pin(hv), .nv_dual_n(nv_d), .nv_quad_n(nv_q), .phase_width(pw), .out_phase(out_phase),
		.busy_pe(busy_pe), .evcr_wr_req(evcr_wr_req), .evcr_value(evcr_value), .rescue(rescue),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .frame(frame), .rx_overrun(rx_overrun),
		.proto(proto), .ext_fallback(ext_fallback), .selected(selected)
	);

	sfp_master mst (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .m_out(m_out), .m_oe(m_oe), .dq(dq));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) flt <= ~flt;

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic wrap_up();
		if (n_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick

	function automatic int wid(input logic first);
		if (exp_p == SFP_PROTO_QUAD && !exp_fb) return 4;
		if (exp_p == SFP_PROTO_DUAL) return 2;
		if (first) return 1;
		return 1 << pw;
	endfunction : wid

	// --------------------
	// Reference model compare
	// --------------------
	always @(posedge clk_sys) begin
		if (!rst && rx_valid === 1'b1 && rx_ready) begin
			chk(16'(rx_data), exp_q.size() > 0 ? 16'(exp_q.pop_front()) : 16'hFFFF);
		end
		if (!rst && frame.end_pulse === 1'b1) begin
			chk(16'(frame.whole_bytes), 16'(exp_whole));
		end
	end

	task automatic do_reset(input logic nd, input logic nq);
		nv_d = nd;
		nv_q = nq;
		rst  = 1'b1;
		repeat (6) tick();
		rst = 1'b0;
		exp_q.delete();
		repeat (8) tick();
		exp_p = !nq ? SFP_PROTO_QUAD : !nd ? SFP_PROTO_DUAL : SFP_PROTO_EXT;
		chk(16'(proto), 16'(exp_p));
	endtask : do_reset

	task automatic run(input logic m, input int n, input int tail, input logic wr, input logic [7:0] v,
		input logic rd);
		logic [7:0] b;
		logic [7:0] r;
		int         pulses;
		pulses      = 0;
		evcr_wr_req = wr;
		evcr_value  = v;
		mst.start(m);
		chk(16'(selected), 16'h0001);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			if (exp_q.size() < SFP_FIFO_DEPTH) exp_q.push_back({i == 0, b});
			pulses += 8 / wid(i == 0);
			mst.xbits(b, wid(i == 0), 8 / wid(i == 0), 1'b1, r);
		end
		// Extra pulses still shift all-ones bytes in at the current width
		for (int k = 0; k < tail * wid(n == 0) / 8; k++) begin
			if (exp_q.size() < SFP_FIFO_DEPTH) exp_q.push_back({1'b0, 8'hFF});
		end
		pulses += tail;
		mst.xbits(8'hFF, 1, tail, 1'b1, r);
		if (n > SFP_FIFO_DEPTH) chk(16'(rx_overrun), 16'h0001);
		if (rd) begin
			tx_data   = 8'($urandom);
			tx_valid  = 1'b1;
			out_phase = 1'b1;
			pulses += 8 / wid(0);
			mst.xbits(8'hFF, wid(0), 8 / wid(0), 1'b0, r);
			tx_valid = 1'b0;
			chk(16'(r), 16'(tx_data));
			chk(16'(dq_e != 4'h0), 16'h0001);
		end
		exp_whole = (pulses % 8 == 0);
		mst.stop();
		out_phase   = 1'b0;
		evcr_wr_req = 1'b0;
		if (wr && exp_whole) exp_p = !v[7] ? SFP_PROTO_QUAD : !v[6] ? SFP_PROTO_DUAL : SFP_PROTO_EXT;
		repeat (4) tick();
		chk(16'(proto), 16'(exp_p));
		chk(16'(dq_e), 16'h0000);
		chk(16'(selected), 16'h0000);
	endtask : run

	initial begin
		repeat (90000) @(posedge clk_sys);
		n_errors++;
		wrap_up();
	end

	// --------------------
	// Main sequence
	// --------------------
	initial begin
		rst         = 1'b1;
		hv          = 1'b0;
		nv_d        = 1'b1;
		nv_q        = 1'b1;
		out_phase   = 1'b0;
		busy_pe     = 1'b0;
		evcr_wr_req = 1'b0;
		evcr_value  = 8'hFF;
		rescue      = 1'b0;
		tx_valid    = 1'b0;
		tx_data     = 8'h00;
		rx_ready    = 1'b1;
		flt         = 1'b0;
		pw          = SFP_LANE_X1;
		exp_fb      = 1'b0;
		exp_whole   = 1'b1;
		n_errors    = 0;
		checked     = 0;
		seed        = $urandom(91709);
		do_reset(1'b1, 1'b0);
		do_reset(1'b0, 1'b0);
		do_reset(1'b0, 1'b1);
		do_reset(1'b1, 1'b1);
		for (int i = 0; i < 6; i++) begin
			pw = sfp_lane_t'(i % 3);
			run(i >= 3, 3, 0, 1'b0, 8'h00, 1'b1);
		end
		pw = SFP_LANE_X1;
		run(1'b0, 2, 0, 1'b1, {2'b10, 6'($urandom)}, 1'b0);
		run(1'b1, 3, 0, 1'b0, 8'h00, 1'b1);
		run(1'b1, 2, 0, 1'b1, {1'b0, 7'($urandom)}, 1'b0);
		run(1'b0, 3, 0, 1'b0, 8'h00, 1'b1);
		run(1'b0, 1, 3, 1'b1, 8'hFF, 1'b0);
		hv      = 1'b1;
		busy_pe = 1'b1;
		repeat (10) tick();
		exp_fb = 1'b1;
		chk(16'(ext_fallback), 16'h0001);
		run(1'b0, 1, 0, 1'b0, 8'h00, 1'b0);
		hv = 1'b0;
		repeat (10) tick();
		exp_fb = 1'b0;
		chk(16'(ext_fallback), 16'h0000);
		run(1'b1, 2, 0, 1'b0, 8'h00, 1'b0);
		busy_pe = 1'b0;
		run(1'b1, 4, 0, 1'b1, 8'hFF, 1'b0);
		run(1'b0, 1, 0, 1'b1, 8'h00, 1'b0);
		rescue = 1'b1;
		tick();
		rescue = 1'b0;
		repeat (4) tick();
		exp_p = SFP_PROTO_EXT;
		chk(16'(proto), 16'(exp_p));
		rx_ready = 1'b0;
		run(1'b0, 20, 0, 1'b0, 8'h00, 1'b0);
		rx_ready = 1'b1;
		for (int i = 0; i < 100 && rx_valid !== 1'b0; i++) tick();
		if (rx_valid !== 1'b0) n_errors++;
		chk(16'(exp_q.size()), 16'h0000);
		wrap_up();
	end
endmodule : testbench
